// ### rtl/flash_settings_defs.vh
`ifndef FLASH_SETTINGS_DEFS_VH
`define FLASH_SETTINGS_DEFS_VH

// ----------------------------------------
// report framing
// ----------------------------------------
`define RPT_LAST_IDX      6'h3f
`define CMD_WRITE_FLASH   8'hb1
`define SUB_CHIP_SETTINGS 8'h00
`define SUB_GP_SETTINGS   8'h01
`define SUB_LAST_KNOWN    8'h04
`define RESP_OK           8'h00
`define RESP_UNSUPPORTED  8'h01

// ----------------------------------------
// report byte positions
// ----------------------------------------
`define CHIP_FIRST_IDX    6'h05
`define CHIP_LAST_IDX     6'h13
`define GP_FIRST_IDX      6'h02
`define GP_LAST_IDX       6'h04

// ----------------------------------------
// field positions
// ----------------------------------------
`define BIT_EDGE_FALL     6
`define BIT_EDGE_RISE     5
`define REF_LEVEL_HI      4
`define REF_LEVEL_LO      3
`define BIT_REF_INTERNAL  2
`define BIT_GP_LEVEL      4
`define BIT_GP_DIR_IN     3

// ----------------------------------------
// function codes
// ----------------------------------------
`define GP_FN_IO          3'h0
`define GP0_LAST_FN       3'h2
`define GP1_LAST_FN       3'h4
`define GP2_LAST_FN       3'h3
`define GP1_FN_INTR       3'h4

// ----------------------------------------
// settings store layout
// ----------------------------------------
`define ST_AW             5
`define ST_REF            5'h00
`define ST_VID_LO         5'h01
`define ST_VID_HI         5'h02
`define ST_PID_LO         5'h03
`define ST_PID_HI         5'h04
`define ST_POWER          5'h05
`define ST_CURRENT        5'h06
`define ST_PW0            5'h07
`define ST_GP0            5'h0f
`define ST_GP1            5'h10
`define ST_GP2            5'h11
`define ST_LAST           5'h11
`define ST_ERASED         8'h00

`endif

// ### rtl/settings_store.v
`timescale 1ns/100ps
`include "flash_settings_defs.vh"

// nonvolatile model: contents survive rst, only power-up clears them
module settings_store
(
   input  wire                  ref_clk,
   input  wire                  wr_en,
   input  wire [`ST_AW-1:0]     wr_addr,
   input  wire [7:0]            wr_data,
   input  wire [`ST_AW-1:0]     rd_addr,
   output reg  [7:0]            rd_data_q
);

   reg [7:0] mem [0:(1<<`ST_AW)-1];
   integer   i;

   initial
   begin
      for (i = 0; i < (1<<`ST_AW); i = i + 1)
         mem[i] = `ST_ERASED;
   end

   always @(posedge ref_clk)
   begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
      rd_data_q <= mem[rd_addr];
   end

endmodule

// ### rtl/edge_flag_detect.v
`timescale 1ns/100ps
`include "flash_settings_defs.vh"

module edge_flag_detect
(
   input  wire ref_clk,
   input  wire rst,
   input  wire pin_in,
   input  wire enable,
   input  wire fall_en,
   input  wire rise_en,
   input  wire flag_clr,
   output reg  flag_q
);

   reg sync1_q;
   reg sync2_q;
   reg prev_q;
   wire rise;
   wire fall;

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         prev_q  <= 1'b0;
      end
      else
      begin
         sync1_q <= pin_in;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   assign fall = prev_q & ~sync2_q;
   assign rise = ~prev_q & sync2_q;

   // a new edge wins over a clear in the same cycle
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         flag_q <= 1'b0;
      else if (enable & ((fall_en & fall) | (rise_en & rise)))
         flag_q <= 1'b1;
      else if (flag_clr)
         flag_q <= 1'b0;
   end

endmodule

// ### rtl/flash_settings_report_decoder.v
`timescale 1ns/100ps
`include "flash_settings_defs.vh"

// What this block does
// - falling-edge enable bit sets interrupt flag on each falling input edge
// - rising-edge enable bit sets interrupt flag on each rising input edge
// - reference level code: 11=4.096V, 10=2.048V, 01=1.024V, 00=off
// - reference source bit: one internal reference, zero supply voltage
// - vendor id from bytes 6/7, product id from bytes 8/9, low first
// - byte 10 kept and reported as power attributes
// - byte 11 kept; requested current is twice it in milliamperes
// - bytes 12 to 19 kept as eight-byte settings password
// - command 0xb1 with sub-code 0x01 is the pin settings write
// - pin zero codes: 000 io, 001 rx indicator, 010 suspend; others ignored
// - pin one codes: io, clock, analog in 1, tx indicator, interrupt
// - pin two codes: io, clock, analog in 2, analog out 1
// - plain output pin drives its stored level bit after reset
// - direction bit, one input zero output, used only in plain io mode
// - unknown write sub-code answers unsupported code in response byte 1

module flash_settings_report_decoder
(
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        rpt_valid,
   input  wire        rpt_sop,
   input  wire [7:0]  rpt_data,
   output reg         resp_valid_q,
   output reg  [7:0]  resp_cmd_q,
   output reg  [7:0]  resp_status_q,
   output wire        settings_ready,
   input  wire        general_pin_zero_i,
   output reg         general_pin_zero_o_q,
   output reg         general_pin_zero_oe_q,
   output reg  [2:0]  general_pin_zero_fn_q,
   input  wire        general_pin_one_i,
   output reg         general_pin_one_o_q,
   output reg         general_pin_one_oe_q,
   output reg  [2:0]  general_pin_one_fn_q,
   input  wire        general_pin_two_i,
   output reg         general_pin_two_o_q,
   output reg         general_pin_two_oe_q,
   output reg  [2:0]  general_pin_two_fn_q,
   output reg  [1:0]  ref_level_q,
   output reg         ref_on_q,
   output reg         ref_internal_q,
   output reg  [15:0] usb_vid_q,
   output reg  [15:0] usb_pid_q,
   output reg  [7:0]  usb_power_attr_q,
   output reg  [8:0]  usb_current_ma_q,
   output reg  [63:0] password_q,
   input  wire        intr_flag_clr,
   output wire        intr_flag
);

   // load walks store entries ST_REF to ST_LAST once after every reset
   localparam ST_LOAD  = 3'b001;
   localparam ST_DRAIN = 3'b010;
   localparam ST_RUN   = 3'b100;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function fn_legal;
      input [1:0] pin;
      input [2:0] code;
      begin
         case (pin)
            2'd0:    fn_legal = (code <= `GP0_LAST_FN);
            2'd1:    fn_legal = (code <= `GP1_LAST_FN);
            default: fn_legal = (code <= `GP2_LAST_FN);
         endcase
      end
   endfunction

   function drives;
      input [7:0] cfg;
      begin
         drives = (cfg[2:0] == `GP_FN_IO) & ~cfg[`BIT_GP_DIR_IN];
      end
   endfunction

   // ----------------------------------------
   // report receiver
   // ----------------------------------------
   reg  [5:0] idx_q;
   reg        in_rpt_q;
   reg        cmd_ok_q;
   reg  [7:0] sub_q;
   wire [5:0] byte_idx;
   wire       byte_take;
   wire       is_chip;
   wire       is_gp;
   wire [1:0] gp_pin;
   wire [5:0] chip_off;
   reg        wr_en;
   reg  [`ST_AW-1:0] wr_addr;

   assign byte_idx  = rpt_sop ? 6'h00 : idx_q;
   assign byte_take = rpt_valid & (rpt_sop | in_rpt_q);
   assign is_chip   = cmd_ok_q & (sub_q == `SUB_CHIP_SETTINGS);
   assign is_gp     = cmd_ok_q & (sub_q == `SUB_GP_SETTINGS);
   assign gp_pin    = byte_idx[1:0] - 2'd2;
   assign chip_off  = byte_idx - `CHIP_FIRST_IDX;

   // a fresh sop always restarts, so a torn report cannot wedge the parser
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         idx_q    <= 6'h00;
         in_rpt_q <= 1'b0;
         cmd_ok_q <= 1'b0;
         sub_q    <= 8'h00;
      end
      else if (byte_take)
      begin
         idx_q    <= byte_idx + 6'h01;
         in_rpt_q <= (byte_idx != `RPT_LAST_IDX);
         if (byte_idx == 6'h00)
            cmd_ok_q <= (rpt_data == `CMD_WRITE_FLASH);
         if (byte_idx == 6'h01)
            sub_q <= rpt_data;
      end
   end

   // bytes go to the store as they arrive; only the recognised ranges land
   always @*
   begin
      wr_en   = 1'b0;
      wr_addr = `ST_REF;
      if (byte_take & is_chip & (byte_idx >= `CHIP_FIRST_IDX)
          & (byte_idx <= `CHIP_LAST_IDX))
      begin
         wr_en   = 1'b1;
         wr_addr = chip_off[`ST_AW-1:0];
      end
      else if (byte_take & is_gp & (byte_idx >= `GP_FIRST_IDX)
               & (byte_idx <= `GP_LAST_IDX))
      begin
         // reserved function codes leave the old pin setting alone
         wr_en   = fn_legal(gp_pin, rpt_data[2:0]);
         wr_addr = `ST_GP0 + {3'b000, gp_pin};
      end
   end

   // ----------------------------------------
   // response
   // ----------------------------------------
   // a foreign command code gets no answer at all
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         resp_valid_q  <= 1'b0;
         resp_cmd_q    <= 8'h00;
         resp_status_q <= `RESP_OK;
      end
      else
      begin
         resp_valid_q <= byte_take & cmd_ok_q & (byte_idx == `RPT_LAST_IDX);
         if (byte_take & cmd_ok_q & (byte_idx == `RPT_LAST_IDX))
         begin
            resp_cmd_q <= `CMD_WRITE_FLASH;
            if (sub_q > `SUB_LAST_KNOWN)
               resp_status_q <= `RESP_UNSUPPORTED;
            else
               resp_status_q <= `RESP_OK;
         end
      end
   end

   // ----------------------------------------
   // store and reset-time load
   // ----------------------------------------
   reg  [2:0]        state_q;
   reg  [`ST_AW-1:0] ld_addr_q;
   reg               cap_v_q;
   reg  [`ST_AW-1:0] cap_a_q;
   wire [7:0]        rd_data;
   reg  [7:0]        act_q [0:`ST_LAST];
   integer           k;

   settings_store u_store
   (
      .ref_clk   (ref_clk),
      .wr_en     (wr_en),
      .wr_addr   (wr_addr),
      .wr_data   (rpt_data),
      .rd_addr   (ld_addr_q),
      .rd_data_q (rd_data)
   );

   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state_q   <= ST_LOAD;
         ld_addr_q <= `ST_REF;
         cap_v_q   <= 1'b0;
         cap_a_q   <= `ST_REF;
      end
      else
      begin
         cap_v_q <= (state_q == ST_LOAD);
         cap_a_q <= ld_addr_q;
         case (state_q)
            ST_LOAD:
            begin
               if (ld_addr_q == `ST_LAST)
                  state_q <= ST_DRAIN;
               else
                  ld_addr_q <= ld_addr_q + 5'h01;
            end
            ST_DRAIN: state_q <= ST_RUN;
            ST_RUN:   state_q <= ST_RUN;
            default:  state_q <= ST_LOAD;
         endcase
      end
   end

   // active copy is only refreshed by the load after reset, never by a write
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         for (k = 0; k <= `ST_LAST; k = k + 1)
            act_q[k] <= `ST_ERASED;
      end
      else if (cap_v_q)
         act_q[cap_a_q] <= rd_data;
   end

   assign settings_ready = (state_q == ST_RUN);

   // ----------------------------------------
   // decoded outputs
   // ----------------------------------------
   always @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         general_pin_zero_o_q  <= 1'b0;
         general_pin_zero_oe_q <= 1'b0;
         general_pin_zero_fn_q <= `GP_FN_IO;
         general_pin_one_o_q   <= 1'b0;
         general_pin_one_oe_q  <= 1'b0;
         general_pin_one_fn_q  <= `GP_FN_IO;
         general_pin_two_o_q   <= 1'b0;
         general_pin_two_oe_q  <= 1'b0;
         general_pin_two_fn_q  <= `GP_FN_IO;
         ref_level_q           <= 2'b00;
         ref_on_q              <= 1'b0;
         ref_internal_q        <= 1'b0;
         usb_vid_q             <= 16'h0000;
         usb_pid_q             <= 16'h0000;
         usb_power_attr_q      <= 8'h00;
         usb_current_ma_q      <= 9'h000;
         password_q            <= 64'h0000000000000000;
      end
      else
      begin
         // pins float as inputs until the load has finished
         general_pin_zero_fn_q <= act_q[`ST_GP0][2:0];
         general_pin_zero_oe_q <= settings_ready & drives(act_q[`ST_GP0]);
         general_pin_zero_o_q  <= act_q[`ST_GP0][`BIT_GP_LEVEL];
         general_pin_one_fn_q  <= act_q[`ST_GP1][2:0];
         general_pin_one_oe_q  <= settings_ready & drives(act_q[`ST_GP1]);
         general_pin_one_o_q   <= act_q[`ST_GP1][`BIT_GP_LEVEL];
         general_pin_two_fn_q  <= act_q[`ST_GP2][2:0];
         general_pin_two_oe_q  <= settings_ready & drives(act_q[`ST_GP2]);
         general_pin_two_o_q   <= act_q[`ST_GP2][`BIT_GP_LEVEL];
         ref_level_q    <= act_q[`ST_REF][`REF_LEVEL_HI:`REF_LEVEL_LO];
         ref_on_q       <= |act_q[`ST_REF][`REF_LEVEL_HI:`REF_LEVEL_LO];
         ref_internal_q <= act_q[`ST_REF][`BIT_REF_INTERNAL];
         usb_vid_q <= {act_q[`ST_VID_HI], act_q[`ST_VID_LO]};
         usb_pid_q <= {act_q[`ST_PID_HI], act_q[`ST_PID_LO]};
         usb_power_attr_q <= act_q[`ST_POWER];
         usb_current_ma_q <= {act_q[`ST_CURRENT], 1'b0};
         password_q <= {act_q[`ST_PW0 + 5'h07], act_q[`ST_PW0 + 5'h06],
                        act_q[`ST_PW0 + 5'h05], act_q[`ST_PW0 + 5'h04],
                        act_q[`ST_PW0 + 5'h03], act_q[`ST_PW0 + 5'h02],
                        act_q[`ST_PW0 + 5'h01], act_q[`ST_PW0]};
      end
   end

   // ----------------------------------------
   // interrupt detection on pin one
   // ----------------------------------------
   // only pin one can raise the flag, and only in its interrupt mode
   edge_flag_detect u_edge
   (
      .ref_clk  (ref_clk),
      .rst      (rst),
      .pin_in   (general_pin_one_i),
      .enable   (settings_ready & (general_pin_one_fn_q == `GP1_FN_INTR)),
      .fall_en  (act_q[`ST_REF][`BIT_EDGE_FALL]),
      .rise_en  (act_q[`ST_REF][`BIT_EDGE_RISE]),
      .flag_clr (intr_flag_clr),
      .flag_q   (intr_flag)
   );

endmodule

// ### test/flash_settings_asserts.sv
`timescale 1ns/100ps
module flash_settings_asserts
(
   input wire        ref_clk,
   input wire        rst,
   input wire        rpt_valid,
   input wire        rpt_sop,
   input wire [7:0]  rpt_data,
   input wire        resp_valid_q,
   input wire [7:0]  resp_cmd_q,
   input wire [7:0]  resp_status_q,
   input wire        settings_ready,
   input wire        general_pin_zero_oe_q,
   input wire [2:0]  general_pin_zero_fn_q,
   input wire [2:0]  general_pin_one_fn_q,
   input wire [2:0]  general_pin_two_fn_q,
   input wire [1:0]  ref_level_q,
   input wire        ref_on_q,
   input wire [15:0] usb_vid_q,
   input wire [8:0]  usb_current_ma_q,
   input wire        intr_flag_clr,
   input wire        intr_flag
);
   reg  [5:0] idx_q;
   reg        live_q;
   reg        ok_q;
   reg        took_q;
   reg  [7:0] sub_q;
   wire       last_d;

   assign last_d = rpt_valid && !rpt_sop && live_q && idx_q == 6'h3f && ok_q;

   // ----
   // report byte tracker
   // ----
   always @(posedge ref_clk or posedge rst)
      if (rst)
      begin
         idx_q  <= 6'h00;
         live_q <= 1'b0;
         ok_q   <= 1'b0;
         took_q <= 1'b0;
         sub_q  <= 8'h00;
      end
      else
      begin
         took_q <= last_d;
         if (rpt_valid && rpt_sop)
         begin
            idx_q  <= 6'h01;
            live_q <= 1'b1;
            ok_q   <= rpt_data == 8'hb1;
         end
         else if (rpt_valid && live_q)
         begin
            if (idx_q == 6'h01)
               sub_q <= rpt_data;
            if (idx_q == 6'h3f)
               live_q <= 1'b0;
            idx_q <= idx_q + 6'h01;
         end
      end

   // ----
   // properties
   // ----
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_last_byte;
      last_d;
   endsequence
   sequence s_one_pulse;
      resp_valid_q ##1 !resp_valid_q;
   endsequence

   a_resp_after_last: assert property (s_last_byte |=> s_one_pulse)
      else $error("response pulse missing after last byte");
   a_resp_cause: assert property (resp_valid_q |-> took_q)
      else $error("response without a finished report");
   a_resp_cmd_echo: assert property (resp_valid_q |-> resp_cmd_q == 8'hb1)
      else $error("response command wrong");
   a_status_code: assert property (resp_valid_q |->
      resp_status_q == ((sub_q > 8'h04) ? 8'h01 : 8'h00))
      else $error("response status wrong");
   a_oe_gate: assert property (general_pin_zero_oe_q |->
      settings_ready && general_pin_zero_fn_q == 3'h0)
      else $error("pin driven outside plain io");
   a_fn_zero_legal: assert property (general_pin_zero_fn_q <= 3'h2)
      else $error("pin zero reserved code active");
   a_fn_one_legal: assert property (general_pin_one_fn_q <= 3'h4)
      else $error("pin one reserved code active");
   a_fn_two_legal: assert property (general_pin_two_fn_q <= 3'h3)
      else $error("pin two reserved code active");
   a_ref_on_level: assert property (ref_on_q == (ref_level_q != 2'h0))
      else $error("reference on flag wrong");
   a_current_even: assert property (settings_ready |-> !usb_current_ma_q[0])
      else $error("current not doubled");
   a_apply_late: assert property (settings_ready && $past(settings_ready, 3) |->
      $stable(usb_vid_q) && $stable(general_pin_zero_fn_q))
      else $error("settings changed without reset");
   a_flag_sticky: assert property (intr_flag && !intr_flag_clr |=> intr_flag)
      else $error("flag dropped without clear");
endmodule

bind flash_settings_report_decoder flash_settings_asserts chk (.*);

// ### test/settings_host.sv
`timescale 1ns/100ps
// ----
// host software model
// ----
module settings_host
(
   input  wire       ref_clk,
   output reg        rpt_valid,
   output reg        rpt_sop,
   output reg  [7:0] rpt_data
);
   logic [7:0] pkt [0:63];

   initial
   begin
      rpt_valid = 1'b0;
      rpt_sop   = 1'b0;
      rpt_data  = 8'h00;
   end

   // slow host leaves idle cycles; idle data is scrambled, not held
   task automatic send(input int gap);
      for (int i = 0; i < 64; i++)
      begin
         @(posedge ref_clk);
         rpt_valid <= 1'b1;
         rpt_sop   <= i == 0;
         rpt_data  <= pkt[i];
         repeat (gap)
         begin
            @(posedge ref_clk);
            rpt_valid <= 1'b0;
            rpt_sop   <= 1'b0;
            rpt_data  <= ~pkt[i];
         end
      end
      @(posedge ref_clk);
      rpt_valid <= 1'b0;
      rpt_sop   <= 1'b0;
      rpt_data  <= ~pkt[63];
   endtask
endmodule

// ### test/flash_settings_report_decoder_bench.sv
`timescale 1ns/100ps
module flash_settings_report_decoder_bench;
   logic        ref_clk, rst, intr_flag_clr;
   logic        general_pin_zero_i, general_pin_one_i, general_pin_two_i;
   wire         rpt_valid, rpt_sop, resp_valid_q, settings_ready, intr_flag;
   wire  [7:0]  rpt_data, resp_cmd_q, resp_status_q, usb_power_attr_q;
   wire         general_pin_zero_o_q, general_pin_zero_oe_q;
   wire         general_pin_one_o_q, general_pin_one_oe_q;
   wire         general_pin_two_o_q, general_pin_two_oe_q;
   wire  [2:0]  general_pin_zero_fn_q, general_pin_one_fn_q, general_pin_two_fn_q;
   wire  [1:0]  ref_level_q;
   wire         ref_on_q, ref_internal_q;
   wire  [15:0] usb_vid_q, usb_pid_q;
   wire  [8:0]  usb_current_ma_q;
   wire  [63:0] password_q;
   wire  [4:0]  obs [0:2];
   int          errors, compares, nresp;
   logic [7:0]  chip [5:19];
   logic [7:0]  gp [0:2];
   logic [7:0]  last_st;

   assign obs[0] = {general_pin_zero_fn_q, general_pin_zero_oe_q, general_pin_zero_o_q};
   assign obs[1] = {general_pin_one_fn_q, general_pin_one_oe_q, general_pin_one_o_q};
   assign obs[2] = {general_pin_two_fn_q, general_pin_two_oe_q, general_pin_two_o_q};

   settings_host host (.ref_clk, .rpt_valid, .rpt_sop, .rpt_data);
   flash_settings_report_decoder dut (.*);

   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk)
   begin
      general_pin_zero_i <= 1'($urandom);
      general_pin_two_i  <= 1'($urandom);
      if (resp_valid_q === 1'b1)
      begin
         nresp   <= nresp + 1;
         last_st <= resp_status_q;
      end
   end

   // ----
   // helpers
   // ----
   function automatic logic [4:0] exp_pin(input logic [7:0] b);
      return {b[2:0], b[2:0] == 3'h0 && !b[3], b[4]};
   endfunction

   task automatic wrap_up;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp)
      begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_all;
      logic [63:0] pw;
      for (int i = 12; i < 20; i++)
         pw[8*(i-12) +: 8] = chip[i];
      check(ref_level_q, chip[5][4:3]);
      check(ref_on_q, |chip[5][4:3]);
      check(ref_internal_q, chip[5][2]);
      check({usb_pid_q, usb_vid_q}, {chip[9], chip[8], chip[7], chip[6]});
      check(usb_power_attr_q, chip[10]);
      check(usb_current_ma_q, {chip[11], 1'b0});
      check(password_q, pw);
      for (int p = 0; p < 3; p++)
         check(obs[p], exp_pin(gp[p]));
   endtask

   task automatic do_reset;
      int n;
      n = 0;
      @(posedge ref_clk);
      rst <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      while (settings_ready !== 1'b1)
      begin
         @(posedge ref_clk);
         #1;
         n++;
         if (n > 40)
         begin
            errors++;
            wrap_up;
         end
      end
      repeat (2) @(posedge ref_clk);
   endtask

   task automatic fill(input logic [7:0] cmd, input logic [7:0] sub);
      for (int i = 2; i < 64; i++)
         host.pkt[i] = 8'($urandom);
      host.pkt[0] = cmd;
      host.pkt[1] = sub;
   endtask

   task automatic take_chip;
      for (int i = 5; i < 20; i++)
         chip[i] = host.pkt[i];
   endtask

   // reserved codes leave that pin's old byte in place
   task automatic take_gp;
      for (int p = 0; p < 3; p++)
         if (host.pkt[2+p][2:0] <= ((p == 0) ? 3'h2 : (p == 1) ? 3'h4 : 3'h3))
            gp[p] = host.pkt[2+p];
   endtask

   task automatic xfer(input int want, input logic [7:0] st);
      int n0;
      n0 = nresp;
      host.send(int'($urandom % 2));
      repeat (3) @(posedge ref_clk);
      check(nresp - n0, want);
      if (want > 0) check(last_st, st);
      if (want > 0) check(resp_cmd_q, 8'hb1);
   endtask

   task automatic pulse_clr;
      intr_flag_clr <= 1'b1;
      @(posedge ref_clk);
      intr_flag_clr <= 1'b0;
      repeat (6) @(posedge ref_clk);
   endtask

   // ----
   // main sequence
   // ----
   initial
   begin
      rst = 1'b1;
      intr_flag_clr = 1'b0;
      general_pin_zero_i = 1'b0;
      general_pin_one_i = 1'b1;
      general_pin_two_i = 1'b0;
      errors = 0;
      compares = 0;
      nresp = 0;
      last_st = 8'h00;
      foreach (chip[i]) chip[i] = 8'h00;
      foreach (gp[i]) gp[i] = 8'h00;
      void'($urandom(56));
      do_reset;
      check_all;
      $display("test power_up done");
      for (int k = 0; k < 4; k++)
      begin
         fill(8'hb1, 8'h00);
         host.pkt[5][4:3] = 2'(k);
         xfer(1, 8'h00);
         check_all;
         take_chip;
         do_reset;
         check_all;
      end
      $display("test chip_settings done");
      for (int c = 0; c < 8; c++)
      begin
         fill(8'hb1, 8'h01);
         for (int p = 0; p < 3; p++)
            host.pkt[2+p][2:0] = 3'(c);
         take_gp;
         xfer(1, 8'h00);
         do_reset;
         check_all;
      end
      $display("test pin_codes done");
      for (int k = 0; k < 5; k++)
      begin
         fill((k == 4) ? 8'h3c : 8'hb1, (k == 3) ? 8'h05 + 8'($urandom % 251) : 8'h02 + 8'(k));
         xfer(k < 4, (k == 3) ? 8'h01 : 8'h00);
      end
      do_reset;
      check_all;
      $display("test refused done");
      for (int e = 0; e < 4; e++)
      begin
         fill(8'hb1, 8'h00);
         host.pkt[5][6:5] = 2'(e);
         take_chip;
         xfer(1, 8'h00);
         fill(8'hb1, 8'h01);
         host.pkt[3][2:0] = 3'h4;
         take_gp;
         xfer(1, 8'h00);
         do_reset;
         check_all;
         pulse_clr;
         check(intr_flag, 1'b0);
         general_pin_one_i <= 1'b0;
         repeat (6) @(posedge ref_clk);
         check(intr_flag, e[1]);
         pulse_clr;
         general_pin_one_i <= 1'b1;
         repeat (6) @(posedge ref_clk);
         check(intr_flag, e[0]);
      end
      $display("test interrupt done");
      wrap_up;
   end
endmodule
